// >>> mua_uart.sv
// Purpose: four-mode uart with ninth bit and hardware address match
// Assumes: all inputs synchronous to clk; timer_ovf is a one-cycle pulse
// Notes: rxd is shared: data in (modes 1-3, mode 0 rx), data out (mode 0 tx)
`timescale 1ns/1ns
module mua_uart #(
  parameter int M0_DIV = mua_pkg::M0_DIV,
  parameter int OVS = mua_pkg::OVS
) (
  input wire logic clk, // 50 MHz cpu clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [7:0] rd_data, // read data, cycle after rd_en
  input wire logic timer_ovf, // selected timer overflow pulse
  input wire logic rxd_in, // receive pin level
  output logic rxd_out, // receive pin drive value, mode 0
  output logic rxd_oe, // receive pin drive enable
  output logic txd_out // transmit pin
);

  if (M0_DIV < 2 || M0_DIV > 16 || OVS < 4 || OVS > 16) begin : g_chk
    $error("mua_uart: divider parameters out of range");
  end

  localparam logic [3:0] M0_LAST = 4'(M0_DIV - 1);
  localparam logic [3:0] M0_HALF = 4'(M0_DIV / 2);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] BIT_LAST = 4'(mua_pkg::DATA_BITS - 1);

  ////////////////////////////////////////////////////////////////////////
  // register state

  mua_pkg::mua_ctrl_s ctrl_reg;
  mua_pkg::mua_ctrl_s wr_ctrl_val;
  mua_pkg::mua_mode_e mode;
  logic fe_reg;
  logic dbl_reg;
  logic fes_reg;
  logic [7:0] station_address_reg;
  logic [7:0] smask_reg;
  logic [7:0] rbuf_reg;
  logic [7:0] rd_data_reg;
  logic wr_ctrl;
  logic wr_buf;
  logic wr_pwr;

  // receive result handed to the register block
  logic rx_load;
  logic [7:0] rx_byte;
  logic rx_b9;
  logic fe_set;
  logic ti_set;

  // given address: masked bits must match; broadcast: zero bits don't care
  function automatic logic addr_hit(input logic [7:0] d,
                                    input logic [7:0] sa,
                                    input logic [7:0] sm);
    logic [7:0] given;
    logic [7:0] bcast;
    given = sa & sm;
    bcast = sa | sm;
    return (((d ^ given) & sm) == 8'h00) || (((d ^ bcast) & bcast) == 8'h00);
  endfunction

  assign wr_ctrl = wr_en && (addr == mua_pkg::OFS_CTRL);
  assign wr_buf = wr_en && (addr == mua_pkg::OFS_BUF);
  assign wr_pwr = wr_en && (addr == mua_pkg::OFS_PWR);
  assign wr_ctrl_val = mua_pkg::mua_ctrl_s'(wdata);
  // bit 7 is a mode bit regardless of what it currently reads as
  assign mode = mua_pkg::mua_mode_e'({ctrl_reg.mode_bit_hi,
                                      ctrl_reg.mode_bit_lo});

  // control register: hardware sets land after software writes, so win
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= mua_pkg::mua_ctrl_s'(mua_pkg::CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wr_ctrl_val;
        if (fes_reg) begin
          ctrl_reg.mode_bit_hi <= ctrl_reg.mode_bit_hi;
        end
      end
      if (rx_load) begin
        ctrl_reg.received_ninth_bit <= rx_b9;
        ctrl_reg.receive_flag <= 1'b1;
      end
      if (ti_set) begin
        ctrl_reg.transmit_done_flag <= 1'b1;
      end
    end
  end

  // framing error: sticky, only a software write of zero clears it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fe_reg <= 1'b0;
    end else begin
      if (wr_ctrl && fes_reg) begin
        fe_reg <= wdata[mua_pkg::CTRL_HI_BIT];
      end
      if (fe_set) begin
        fe_reg <= 1'b1;
      end
    end
  end

  // power control, station address and mask
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dbl_reg <= 1'b0;
      fes_reg <= 1'b0;
      station_address_reg <= mua_pkg::BYTE_RST;
      smask_reg <= mua_pkg::BYTE_RST;
    end else begin
      if (wr_pwr) begin
        dbl_reg <= wdata[mua_pkg::PWR_DBL_BIT];
        fes_reg <= wdata[mua_pkg::PWR_FES_BIT];
      end
      if (wr_en && (addr == mua_pkg::OFS_STATION_ADDRESS)) begin
        station_address_reg <= wdata;
      end
      if (wr_en && (addr == mua_pkg::OFS_SMASK)) begin
        smask_reg <= wdata;
      end
    end
  end

  // receive buffer changes only on an accepted frame
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rbuf_reg <= mua_pkg::BYTE_RST;
    end else if (rx_load) begin
      rbuf_reg <= rx_byte;
    end
  end

  // read port: data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b || !rd_en) begin
      rd_data_reg <= 8'h00;
    end else begin
      case (addr)
        mua_pkg::OFS_CTRL: begin
          rd_data_reg <= {fes_reg ? fe_reg : ctrl_reg.mode_bit_hi,
                          ctrl_reg[6:0]};
        end
        mua_pkg::OFS_BUF: rd_data_reg <= rbuf_reg;
        mua_pkg::OFS_PWR: begin
          rd_data_reg <= {dbl_reg, fes_reg, 6'h00};
        end
        mua_pkg::OFS_STATION_ADDRESS: rd_data_reg <= station_address_reg;
        mua_pkg::OFS_SMASK: rd_data_reg <= smask_reg;
        default: rd_data_reg <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oversampling tick, OVS ticks per bit in modes 1-3

  logic half_reg;
  logic base_tick;
  logic samp;

  // mode 2 counts the cpu clock, modes 1 and 3 count timer overflows
  assign base_tick = (mode == mua_pkg::MODE2) ? 1'b1 : timer_ovf;
  assign samp = base_tick && (dbl_reg || half_reg);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      half_reg <= 1'b0;
    end else if (base_tick) begin
      half_reg <= !half_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode 0 synchronous shifter

  logic m0_busy_reg;
  logic m0_rx_reg;
  logic [7:0] m0_sh_reg;
  logic [3:0] m0_cnt_reg;
  logic [3:0] m0_ph_reg;
  logic m0_tx_go;
  logic m0_rx_go;
  logic m0_shift;
  logic m0_done;

  assign m0_tx_go = wr_buf && (mode == mua_pkg::MODE0) && !m0_busy_reg;
  // reception starts when software enables it with the flag clear
  assign m0_rx_go = wr_ctrl && (mode == mua_pkg::MODE0) && !m0_busy_reg &&
                    wr_ctrl_val.rx_enable &&
                    !wr_ctrl_val.receive_flag;
  assign m0_shift = m0_busy_reg && (m0_ph_reg == M0_LAST);
  assign m0_done = m0_shift && (m0_cnt_reg == BIT_LAST);

  // one bit per M0_DIV clocks, sampled at the end of the high phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      m0_busy_reg <= 1'b0;
      m0_rx_reg <= 1'b0;
      m0_sh_reg <= 8'h00;
      m0_cnt_reg <= 4'h0;
      m0_ph_reg <= 4'h0;
    end else if (!m0_busy_reg) begin
      m0_cnt_reg <= 4'h0;
      m0_ph_reg <= 4'h0;
      if (m0_tx_go) begin
        m0_busy_reg <= 1'b1;
        m0_rx_reg <= 1'b0;
        m0_sh_reg <= wdata;
      end else if (m0_rx_go) begin
        m0_busy_reg <= 1'b1;
        m0_rx_reg <= 1'b1;
      end
    end else begin
      m0_ph_reg <= m0_shift ? 4'h0 : 4'(m0_ph_reg + 4'h1);
      if (m0_shift) begin
        // lsb leaves first; received bits enter at the top
        m0_sh_reg <= {m0_rx_reg ? rxd_in : 1'b1, m0_sh_reg[7:1]};
        m0_cnt_reg <= 4'(m0_cnt_reg + 4'h1);
        if (m0_done) begin
          m0_busy_reg <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // modes 1-3 transmitter

  logic tx_busy_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [3:0] tx_ph_reg;
  logic tx_step;

  assign tx_step = tx_busy_reg && samp && (tx_ph_reg == OVS_LAST);

  // writes to the buffer while a frame is out are dropped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= '1;
      tx_left_reg <= 4'h0;
      tx_ph_reg <= 4'h0;
    end else if (!tx_busy_reg) begin
      tx_ph_reg <= 4'h0;
      if (wr_buf && (mode != mua_pkg::MODE0)) begin
        tx_busy_reg <= 1'b1;
        // mode 1 sends the stop bit where the ninth bit would sit
        tx_sh_reg <= {1'b1, (mode == mua_pkg::MODE1) ? 1'b1 :
                      ctrl_reg.transmit_ninth_bit, wdata, 1'b0};
        tx_left_reg <= (mode == mua_pkg::MODE1) ? mua_pkg::M1_TX_BITS :
                       mua_pkg::M2_TX_BITS;
      end
    end else if (samp) begin
      tx_ph_reg <= (tx_ph_reg == OVS_LAST) ? 4'h0 : 4'(tx_ph_reg + 4'h1);
      if (tx_step) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        tx_left_reg <= 4'(tx_left_reg - 4'h1);
        if (tx_left_reg == 4'h1) begin
          tx_busy_reg <= 1'b0;
        end
      end
    end
  end

  assign ti_set = m0_done ? !m0_rx_reg : (tx_step && tx_left_reg == 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // modes 1-3 receiver

  mua_pkg::mua_rx_e rx_state;
  logic rx_prev_reg;
  logic [3:0] rx_ph_reg;
  logic [3:0] rx_idx_reg;
  logic [8:0] rx_sh_reg;
  logic rx_pt;
  logic is_m1;
  logic [3:0] rx_last;
  logic [7:0] as_byte;
  logic as_b9;
  logic as_pass;
  logic as_final;

  assign is_m1 = (mode == mua_pkg::MODE1);
  assign rx_pt = samp && (rx_ph_reg == mua_pkg::SAMPLE_PT);
  assign rx_last = is_m1 ? BIT_LAST : 4'(BIT_LAST + 4'h1);
  // mode 1 has eight bits in the top of the shifter, modes 2/3 nine
  assign as_byte = is_m1 ? rx_sh_reg[8:1] : rx_sh_reg[7:0];
  // ninth bit: stop bit in mode 1, real ninth bit otherwise
  assign as_b9 = is_m1 ? rxd_in : rx_sh_reg[8];
  assign as_final = (rx_state == mua_pkg::RX_STOP) && rx_pt;
  // filter: mode 1 needs a good stop; modes 2/3 an addressed match
  always_comb begin
    if (!ctrl_reg.multiproc_filter) begin
      as_pass = 1'b1;
    end else if (is_m1) begin
      as_pass = rxd_in;
    end else begin
      as_pass = rx_sh_reg[8] &&
                addr_hit(as_byte, station_address_reg, smask_reg);
    end
  end

  // stop bit is checked in every async mode; a low stop flags the error, and in mode 1 with the filter also drops the frame
  assign fe_set = as_final && !rxd_in;

  // final shift pulse decides; a rejected frame vanishes
  assign rx_load = (as_final && !ctrl_reg.receive_flag && as_pass) ||
                   (m0_done && m0_rx_reg &&
                    !ctrl_reg.receive_flag);
  assign rx_byte = m0_done ? {rxd_in, m0_sh_reg[7:1]} : as_byte;
  assign rx_b9 = m0_done ? ctrl_reg.received_ninth_bit : as_b9;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rxd_in;
    end
  end

  // edge-triggered start, mid-bit sampling at phase SAMPLE_PT
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_state <= mua_pkg::RX_IDLE;
      rx_ph_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
    end else if (!ctrl_reg.rx_enable || mode == mua_pkg::MODE0) begin
      rx_state <= mua_pkg::RX_IDLE;
    end else begin
      if (samp) begin
        rx_ph_reg <= (rx_ph_reg == OVS_LAST) ? 4'h0 :
                     4'(rx_ph_reg + 4'h1);
      end
      case (rx_state)
        mua_pkg::RX_IDLE: begin
          rx_ph_reg <= 4'h0;
          if (rx_prev_reg && !rxd_in) begin
            rx_state <= mua_pkg::RX_START;
          end
        end
        mua_pkg::RX_START: begin
          // a start bit that is high again at mid-bit was noise
          if (rx_pt) begin
            rx_idx_reg <= 4'h0;
            rx_state <= rxd_in ? mua_pkg::RX_IDLE : mua_pkg::RX_BITS;
          end
        end
        mua_pkg::RX_BITS: begin
          if (rx_pt) begin
            rx_sh_reg <= {rxd_in, rx_sh_reg[8:1]};
            rx_idx_reg <= 4'(rx_idx_reg + 4'h1);
            if (rx_idx_reg == rx_last) begin
              rx_state <= mua_pkg::RX_STOP;
            end
          end
        end
        mua_pkg::RX_STOP: begin
          if (rx_pt) begin
            rx_state <= mua_pkg::RX_IDLE;
          end
        end
        default: rx_state <= mua_pkg::RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers, all registered

  logic txd_reg;
  logic rxd_out_reg;
  logic rxd_oe_reg;

  // mode 0: clock low for the first half of each bit slot
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txd_reg <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg <= 1'b0;
    end else begin
      if (m0_busy_reg) begin
        txd_reg <= (m0_ph_reg >= M0_HALF);
      end else begin
        txd_reg <= tx_busy_reg ? tx_sh_reg[0] : 1'b1;
      end
      rxd_out_reg <= m0_sh_reg[0];
      rxd_oe_reg <= m0_busy_reg && !m0_rx_reg;
    end
  end

  assign rd_data = rd_data_reg;
  assign txd_out = txd_reg;
  assign rxd_out = rxd_out_reg;
  assign rxd_oe = rxd_oe_reg;

endmodule

// >>> mua_pkg.sv
// Purpose: constants and types for the multimode uart with address match
// Assumes: 50 MHz clk, 8-bit register port, one timer overflow pulse input
// Notes: register offsets and field positions are defined here; the bench, props and read mux also hard-code some
package mua_pkg;

  // register map
  localparam logic [7:0] OFS_CTRL = 8'h98;
  localparam logic [7:0] OFS_BUF = 8'h99;
  localparam logic [7:0] OFS_PWR = 8'h9a;
  localparam logic [7:0] OFS_STATION_ADDRESS = 8'h9b;
  localparam logic [7:0] OFS_SMASK = 8'h9c;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // power control fields and the control register's bit 7
  localparam int PWR_DBL_BIT = 7;
  localparam int PWR_FES_BIT = 6;
  localparam int CTRL_HI_BIT = 7;

  // timing
  localparam int M0_DIV = 6;
  localparam int OVS = 16;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] M1_TX_BITS = 4'ha;
  localparam logic [3:0] M2_TX_BITS = 4'hb;
  localparam logic [3:0] SAMPLE_PT = 4'h7;

  typedef enum logic [1:0] {
    MODE0 = 2'b00,
    MODE1 = 2'b01,
    MODE2 = 2'b10,
    MODE3 = 2'b11
  } mua_mode_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10,
    RX_STOP = 2'b11
  } mua_rx_e;

  typedef struct packed {
    logic mode_bit_hi;
    logic mode_bit_lo;
    logic multiproc_filter;
    logic rx_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_flag;
  } mua_ctrl_s;

endpackage

// >>> mua_uart_props.sv
// Purpose: port-level checks for the multimode uart
// Assumes: timer_ovf from the bench is strictly periodic
// Notes: mode and rate selects are mirrored from register writes
`timescale 1ns/1ns
module mua_uart_props (
  input wire logic clk, // cpu clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [7:0] rd_data, // read data
  input wire logic timer_ovf, // timer overflow pulse
  input wire logic rxd_in, // receive pin level
  input wire logic rxd_out, // receive pin drive
  input wire logic rxd_oe, // receive pin enable
  input wire logic txd_out // transmit pin
);
  logic [1:0] mode_reg;
  logic fes_reg;
  logic dbl_reg;
  logic [15:0] low_reg;
  logic [15:0] ovf_reg;
  logic ovf_d_reg;
  logic buf_wr;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////
  assign buf_wr = wr_en && addr == mua_pkg::OFS_BUF;
  // mode mirror; bit 7 is skipped while it stands for the error flag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_reg <= 2'h0;
      fes_reg <= 1'b0;
      dbl_reg <= 1'b0;
    end else if (wr_en && addr == mua_pkg::OFS_PWR) begin
      fes_reg <= wdata[6];
      dbl_reg <= wdata[7];
    end else if (wr_en && addr == mua_pkg::OFS_CTRL) begin
      mode_reg <= {fes_reg ? mode_reg[1] : wdata[7], wdata[6]};
    end
  end
  // the transmitter steps on a tick one clock before its pin moves, so
  // the pulse that counts for a low run is the one seen a clock earlier
  always_ff @(posedge clk) begin
    ovf_d_reg <= timer_ovf;
  end
  // length of each low run on txd, in clocks and in timer pulses
  // limitation: at half rate the start bit may still run one tick short
  always_ff @(posedge clk) begin
    if (!rst_b || txd_out) begin
      low_reg <= 16'h0000;
      ovf_reg <= 16'h0000;
    end else begin
      low_reg <= low_reg + 16'h0001;
      ovf_reg <= ovf_reg + {15'h0000, ovf_d_reg};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  chk_rd_quiet: assert property (
    !rd_en |=> rd_data == 8'h00) else $error("read data not idle");
  chk_m0_clk_low: assert property (
    $rose(txd_out) && mode_reg == 2'h0 |-> low_reg == 16'h0003)
    else $error("shift clock low phase wrong");
  chk_m0_data_hold: assert property (
    $rose(txd_out) && rxd_oe |-> $stable(rxd_out)[*2])
    else $error("shift data moved at clock rise");
  chk_oe_release: assert property (
    $fell(rxd_oe) |-> txd_out) else $error("shift clock left low");
  chk_m0_start: assert property (
    buf_wr && mode_reg == 2'h0 |-> ##[1:3] rxd_oe)
    else $error("shift transfer did not start");
  chk_async_start: assert property (
    buf_wr && mode_reg != 2'h0 |-> ##[1:3] !txd_out)
    else $error("start bit missing");
  chk_m2_rate: assert property (
    $rose(txd_out) && mode_reg == 2'h2 |->
    low_reg % (dbl_reg ? 16 : 32) == 0) else $error("fixed rate wrong");
  chk_timer_rate: assert property (
    $rose(txd_out) && mode_reg[0] |->
    ovf_reg % (dbl_reg ? 16 : 32) == 0) else $error("timer rate wrong");
endmodule

// >>> mua_remote_node.sv
// Purpose: remote serial node facing the uart pins
// Assumes: bit times are given in clk cycles by the caller
// Notes: idle line is high; shift data taken on shift clock rise
`timescale 1ns/1ns
module mua_remote_node (
  input wire logic clk, // cpu clock
  input wire logic txd_out, // uart transmit pin
  input wire logic rxd_out, // uart drive on receive pin
  input wire logic rxd_oe, // uart enable on receive pin
  output logic node_drv // our drive on receive line
);
  logic [7:0] m0_cap;
  logic [7:0] m0_src;
  logic m0_feed;
  //////////////////////////////////////////////////////////////////////////
  initial node_drv = 1'b1;
  initial m0_cap = 8'h00;
  initial m0_src = 8'hff;
  initial m0_feed = 1'b0;
  // shift mode receive: next bit goes out on each falling shift clock,
  // so it has settled well before the uart samples at the high phase end
  always @(negedge txd_out) begin
    if (m0_feed && !rxd_oe) begin
      node_drv <= m0_src[0];
      m0_src <= {1'b1, m0_src[7:1]};
    end
  end
  // arm or disarm the shift mode source; disarming idles the line high
  task automatic feed_m0(input logic [7:0] d, input logic on);
    m0_src = d;
    m0_feed = on;
    if (!on) node_drv <= 1'b1;
  endtask
  // shift register side, lsb arrives first
  always @(posedge txd_out) begin
    if (rxd_oe) begin
      m0_cap <= {rxd_out, m0_cap[7:1]};
    end
  end
  // one frame out, f[0] is the start bit, ninth marks address
  task automatic send_frame(input logic [10:0] f, input int n, input int bt);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      node_drv <= f[i];
      repeat (bt) @(posedge clk);
    end
    node_drv <= 1'b1;
    repeat (bt) @(posedge clk);
  endtask
  // one frame in, sampled at mid bit
  task automatic get_frame(input int n, input int bt, output logic [10:0] f);
    f = 11'h7ff;
    @(negedge txd_out);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd_out;
      repeat (bt) @(posedge clk);
    end
  endtask
endmodule

// >>> tb_top.sv
// Purpose: self-checking bench for the multimode uart
// Assumes: timer pulse every other clock, so 32 clocks a bit at 16x
// Notes: expected bytes are worked out by hand from the frame layout
`timescale 1ns/1ns
module tb_top;
  logic clk;
  logic rst_b;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_data;
  logic timer_ovf;
  logic rxd_out;
  logic rxd_oe;
  logic txd_out;
  logic node_drv;
  logic rxd_line;
  logic [10:0] fr;
  int errors;
  int cmp_count;
  logic [7:0] d_t [5] = '{8'h15, 8'h15, 8'h16, 8'hff, 8'ha5};
  logic [4:0] nine_t = 5'b11101;
  logic [4:0] exp_t = 5'b11001;
  //////////////////////////////////////////////////////////////////////////
  // receive line: uart drives it only for shift-mode transmit
  assign rxd_line = rxd_oe ? rxd_out : node_drv;
  mua_uart DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .timer_ovf(timer_ovf), .rxd_in(rxd_line), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out));
  mua_remote_node node (.clk(clk), .txd_out(txd_out), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .node_drv(node_drv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // overflow every other clock keeps the timer rate exact
  always @(posedge clk) timer_ovf <= ~timer_ovf;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdv(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rdv(a, v);
    chk({3'h0, v}, {3'h0, exp});
  endtask
  task automatic send(input logic [10:0] f, input int n);
    node.send_frame(f, n, 32);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int a = 8'h98; a <= 8'h9d; a++) rd(8'(a), 8'h00);
    wr(8'h9d, 8'hff);
    rd(8'h9d, 8'h00);
    wr(mua_pkg::OFS_STATION_ADDRESS, 8'h35);
    wr(mua_pkg::OFS_SMASK, 8'h0f);
    rd(mua_pkg::OFS_STATION_ADDRESS, 8'h35);
    rd(mua_pkg::OFS_SMASK, 8'h0f);
  endtask
  // shift mode transmit with the filter bit set, which must not matter
  task automatic t_m0;
    logic [7:0] v;
    v = 8'h00;
    wr(mua_pkg::OFS_CTRL, 8'h20);
    wr(mua_pkg::OFS_BUF, 8'ha5);
    for (int i = 0; i < 100 && !v[1]; i++) rdv(mua_pkg::OFS_CTRL, v);
    chk({3'h0, v}, 11'h022);
    chk({3'h0, node.m0_cap}, 11'h0a5);
  endtask
  task automatic t_m2tx;
    wr(mua_pkg::OFS_PWR, 8'h80);
    wr(mua_pkg::OFS_CTRL, 8'h88);
    fork
      wr(mua_pkg::OFS_BUF, 8'h3c);
      node.get_frame(11, 16, fr);
    join
    chk(fr, {2'b11, 8'h3c, 1'b0});
    rd(mua_pkg::OFS_CTRL, 8'h8a);
  endtask
  task automatic t_m1;
    wr(mua_pkg::OFS_CTRL, 8'h50);
    fork
      wr(mua_pkg::OFS_BUF, 8'h81);
      node.get_frame(10, 32, fr);
    join
    chk(fr, {2'b11, 8'h81, 1'b0});
    wr(mua_pkg::OFS_CTRL, 8'h50);
    send({2'b01, 8'h6e, 1'b0}, 10);
    rd(mua_pkg::OFS_BUF, 8'h6e);
    rd(mua_pkg::OFS_CTRL, 8'h55);
  endtask
  // flag still set, then receiver off, then stop-bit filter
  task automatic t_reject;
    send({2'b01, 8'h11, 1'b0}, 10);
    rd(mua_pkg::OFS_BUF, 8'h6e);
    rd(mua_pkg::OFS_CTRL, 8'h55);
    wr(mua_pkg::OFS_CTRL, 8'h40);
    send({2'b01, 8'h22, 1'b0}, 10);
    rd(mua_pkg::OFS_CTRL, 8'h40);
    wr(mua_pkg::OFS_CTRL, 8'h70);
    send({2'b00, 8'h33, 1'b0}, 10);
    rd(mua_pkg::OFS_CTRL, 8'h70);
    send({2'b01, 8'h33, 1'b0}, 10);
    rd(mua_pkg::OFS_BUF, 8'h33);
    rd(mua_pkg::OFS_CTRL, 8'h75);
  endtask
  task automatic t_fe;
    wr(mua_pkg::OFS_CTRL, 8'h50);
    wr(mua_pkg::OFS_PWR, 8'hc0);
    send({2'b00, 8'h44, 1'b0}, 10);
    rd(mua_pkg::OFS_CTRL, 8'hd1);
    send({2'b01, 8'h55, 1'b0}, 10);
    rd(mua_pkg::OFS_CTRL, 8'hd1);
    wr(mua_pkg::OFS_CTRL, 8'h50);
    rd(mua_pkg::OFS_CTRL, 8'h50);
    wr(mua_pkg::OFS_PWR, 8'h80);
    rd(mua_pkg::OFS_CTRL, 8'h50);
  endtask
  // slow fixed rate, stop bit sent low, frame still accepted
  task automatic t_m2rx;
    wr(mua_pkg::OFS_PWR, 8'h00);
    wr(mua_pkg::OFS_CTRL, 8'h90);
    rd(mua_pkg::OFS_CTRL, 8'h90);
    send({2'b00, 8'h5a, 1'b0}, 11);
    rd(mua_pkg::OFS_CTRL, 8'h91);
    rd(mua_pkg::OFS_BUF, 8'h5a);
  endtask
  // given, data byte, miss, broadcast, masked don't-care bits
  task automatic t_m3;
    wr(mua_pkg::OFS_PWR, 8'h80);
    for (int i = 0; i < 5; i++) begin
      wr(mua_pkg::OFS_CTRL, 8'hf0);
      send({1'b1, nine_t[i], d_t[i], 1'b0}, 11);
      rd(mua_pkg::OFS_CTRL, exp_t[i] ? 8'hf5 : 8'hf0);
      if (exp_t[i]) rd(mua_pkg::OFS_BUF, d_t[i]);
    end
  endtask
  // shift mode receive with the filter bit set, which must not matter
  task automatic t_m0rx;
    logic [7:0] v;
    v = 8'h00;
    wr(mua_pkg::OFS_CTRL, 8'h20);
    node.feed_m0(8'h96, 1'b1);
    wr(mua_pkg::OFS_CTRL, 8'h30);
    for (int i = 0; i < 100 && !v[0]; i++) rdv(mua_pkg::OFS_CTRL, v);
    chk({3'h0, v}, 11'h031);
    rd(mua_pkg::OFS_BUF, 8'h96);
    node.feed_m0(8'hff, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    errors = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    timer_ovf = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_m0;
    t_m2tx;
    t_m1;
    t_reject;
    t_fe;
    t_m2rx;
    t_m3;
    t_m0rx;
    complete_run;
  end
  // hang guard, well past the few thousand clocks the run needs
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    complete_run;
  end
endmodule
bind mua_uart mua_uart_props chk_i (.clk(clk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .timer_ovf(timer_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
  .rxd_oe(rxd_oe), .txd_out(txd_out));
